// ==== verilog/ibcr_config_regs.sv ====
// Configuration register bank of the ISA bridge function.
// Assumes config cycles are decoded upstream into a one-cycle select strobe
// with AD[7:2] index, active-high byte enables and write data, all on mclk.
//
// Contract
// - Command resets to 0007h; bits 2:0 stay one and ignore writes.
// - Command bits 15:10, 9, 7, 5, 4 read zero, writes ignored.
// - Command bit 8 writable, resets zero, never drives system error; bit 6 R/W.
// - Command bit 3 resets zero; special cycles ignored while clear.
// - Status resets 0200h; bits 10:9 fixed at 01.
// - Status bits 15,13,12,11,8 are error flags; bit 14 system error flag.
// - Status bits 7:0 read zero.
// - Class code reads 060100h.
// - Header type reads 80h, multi-function, standard layout.
// - Control resets 20h; bit 5 enables interrupt acknowledge answer; 7,4 read zero.
// - Control bit 3 moves subtractive decode one clock earlier.
// - Control bit 2 posts memory writes toward ISA.
// - Control bit 1 selects retry; clear means wait states until idle.
// - Control bit 0 raises NMI from any status error flag but system error.
// - Scatter/gather relocation gives I/O bits 15:8, reset 04h.
// - Line buffer: ISA master field 3:2, DMA field 1:0.
// - Disk IRQ routing: primary bits 7:4 reset Eh, secondary 3:0 reset Fh.
// - Line routing four 4-bit fields; 0,1,2,8,13 disable routing.
// - Timer base holds bits 15:2, reset 0078h; decoded only with bit 0 set.
// - Top of memory (value+1) MByte; 1M..top forwarded.
// - Bits 3..0 forward E, A-B, 8-9, 0-7 segments; low firmware select overrides bit 3.
// - Option ROM enable bits forward their add-on areas; reset 00h.
// - Access by select with AD[1:0] low; AD[7:2] picks word, byte enables lanes.
// - Reserved bits read zero; writes there change nothing.
`timescale 1ns/1ps
module ibcr_config_regs
    import ibcr_pkg::*;
#(
    parameter logic [7:0] REVISION = 8'h3c  // Arbitrary value
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        cfgSelect,
    input  wire logic        cfgWrite,
    input  wire logic [7:0]  cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWriteData,
    output logic [31:0]      cfgReadData,
    output logic             cfgReadValid,
    input  wire logic        parityErrorSeen,
    input  wire logic        masterAbortReceived,
    input  wire logic        targetAbortReceived,
    input  wire logic        targetAbortSignaled,
    input  wire logic        masterParityError,
    input  wire logic        systemErrorSignaled,
    input  wire logic        specialCycleSeen,
    input  wire logic [23:0] isaMemAddr,
    input  wire logic [7:0]  firmwareSelectReg,
    input  wire logic [15:0] hostIoAddr,
    output logic             specialCycleTaken,
    output logic             serrDriveLow,
    output logic             intAckResponseEn,
    output logic             earlySubtractiveDecode,
    output logic             writePostingEn,
    output logic             delayedRetryEn,
    output logic             nmiRequest,
    output logic [7:0]       sgIoBase,
    output logic [3:0]       dmaBufferConfig,
    output logic [3:0]       primaryDiskIrqSelect,
    output logic [3:0]       secondaryDiskIrqSelect,
    output logic [15:0]      lineChannels,
    output logic [3:0]       lineRouteValid,
    output logic             fwTimerHit,
    output logic             isaForwardToHost,
    output logic [7:0]       optionRomForward
);
    import ibcr_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] laneMerge(input logic [7:0] oldV, input logic [7:0] newV,
                                             input logic en, input logic [7:0] mask);
        laneMerge = en ? ((oldV & ~mask) | (newV & mask)) : oldV;
    endfunction : laneMerge

    function automatic logic routeOk(input logic [3:0] ch);
        routeOk = !(ch == 4'h0 || ch == 4'h1 || ch == 4'h2 || ch == 4'h8 || ch == 4'hd);
    endfunction : routeOk

    ibcr_state_type s_q;
    ibcr_state_type s_d;
    logic           hit;
    logic           wr;
    logic [15:0]    errEvents;
    logic [15:0]    w1c;
    logic [5:0]     idx;

    assign idx = cfgAddr[7:2];
    assign hit = cfgSelect && (cfgAddr[1:0] == 2'b00);
    assign wr  = hit && cfgWrite && !reset;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        errEvents = {parityErrorSeen, systemErrorSignaled, masterAbortReceived,
                     targetAbortReceived, targetAbortSignaled, 2'b00, masterParityError,
                     8'h00};
        w1c = 16'h0000;
        if (wr && idx == `IBCR_IDX_CMDSTAT) begin
            // System error flag clears like the others, though it never feeds NMI
            w1c = {cfgByteEn[3] ? cfgWriteData[31:24] : 8'h00,
                   cfgByteEn[2] ? cfgWriteData[23:16] : 8'h00}
                  & (`IBCR_STAT_W1C_MASK | 16'h4000);
        end
        // Set beats the clear in the same cycle
        s_d.busStatusFlags = ((s_q.busStatusFlags & ~w1c) | (errEvents & `IBCR_STAT_W1C_MASK)
                              | (errEvents & (16'h1 << `IBCR_STAT_SSE)))
                             & (`IBCR_STAT_W1C_MASK | 16'h4000) | `IBCR_STAT_RESET;
        if (wr) begin
            if (idx == `IBCR_IDX_CMDSTAT) begin
                s_d.commandControl[7:0] = laneMerge(s_q.commandControl[7:0],
                    cfgWriteData[7:0], cfgByteEn[0], 8'(`IBCR_CMD_RW_MASK));
                s_d.commandControl[15:8] = laneMerge(s_q.commandControl[15:8],
                    cfgWriteData[15:8], cfgByteEn[1], 8'h01);
            end else if (idx == `IBCR_IDX_CTRL) begin
                s_d.bridgeBusControl = laneMerge(s_q.bridgeBusControl, cfgWriteData[7:0],
                    cfgByteEn[0], `IBCR_CTRL_RW_MASK);
                s_d.sgIoRelocationBase = laneMerge(s_q.sgIoRelocationBase,
                    cfgWriteData[15:8], cfgByteEn[1], 8'hff);
                s_d.lineBufferConfig = laneMerge(s_q.lineBufferConfig,
                    cfgWriteData[23:16], cfgByteEn[2], `IBCR_LINEBUF_MASK);
                s_d.diskIrqRouting = laneMerge(s_q.diskIrqRouting,
                    cfgWriteData[31:24], cfgByteEn[3], 8'hff);
            end else if (idx == `IBCR_IDX_IRQROUTE) begin
                s_d.busIrqLineRouting[7:0] = laneMerge(s_q.busIrqLineRouting[7:0],
                    cfgWriteData[7:0], cfgByteEn[0], 8'hff);
                s_d.busIrqLineRouting[15:8] = laneMerge(s_q.busIrqLineRouting[15:8],
                    cfgWriteData[15:8], cfgByteEn[1], 8'hff);
                s_d.firmwareTimerBase[7:0] = laneMerge(s_q.firmwareTimerBase[7:0],
                    cfgWriteData[23:16], cfgByteEn[2], 8'hfd);
                s_d.firmwareTimerBase[15:8] = laneMerge(s_q.firmwareTimerBase[15:8],
                    cfgWriteData[31:24], cfgByteEn[3], 8'hff);
            end else if (idx == `IBCR_IDX_DECODE) begin
                s_d.isaToHostDecode = laneMerge(s_q.isaToHostDecode, cfgWriteData[7:0],
                    cfgByteEn[0], 8'hff);
                s_d.optionRomForwardEnable = laneMerge(s_q.optionRomForwardEnable,
                    cfgWriteData[15:8], cfgByteEn[1], 8'hff);
            end
            // Other indices: cycle completes, nothing changes
        end
        s_d.commandControl = (s_d.commandControl & `IBCR_CMD_RW_MASK)
                             | `IBCR_CMD_FIXED_ONES;
        s_d.readData = 32'h0000_0000;
        if (hit && !cfgWrite) begin
            if (idx == `IBCR_IDX_CMDSTAT) begin
                s_d.readData = {s_q.busStatusFlags, s_q.commandControl};
            end else if (idx == `IBCR_IDX_CLASSREV) begin
                s_d.readData = {`IBCR_CLASS_CODE, REVISION};
            end else if (idx == `IBCR_IDX_HEADER) begin
                s_d.readData = {8'h00, `IBCR_HEADER_TYPE, 16'h0000};
            end else if (idx == `IBCR_IDX_CTRL) begin
                s_d.readData = {s_q.diskIrqRouting, s_q.lineBufferConfig,
                                s_q.sgIoRelocationBase, s_q.bridgeBusControl};
            end else if (idx == `IBCR_IDX_IRQROUTE) begin
                s_d.readData = {s_q.firmwareTimerBase, s_q.busIrqLineRouting};
            end else if (idx == `IBCR_IDX_DECODE) begin
                s_d.readData = {16'h0000, s_q.optionRomForwardEnable, s_q.isaToHostDecode};
            end
        end
        // Any error flag except system error raises NMI when enabled
        s_d.nmi = s_q.bridgeBusControl[`IBCR_CTRL_NMI_EN]
                  && |(s_q.busStatusFlags & `IBCR_STAT_ERR_MASK);
        if (reset) begin
            s_d.commandControl         = `IBCR_CMD_RESET;
            s_d.busStatusFlags         = `IBCR_STAT_RESET;
            s_d.bridgeBusControl       = `IBCR_CTRL_RESET;
            s_d.sgIoRelocationBase     = `IBCR_SG_RESET;
            s_d.lineBufferConfig       = `IBCR_LINEBUF_RESET;
            s_d.diskIrqRouting         = `IBCR_DISK_IRQ_RESET;
            s_d.busIrqLineRouting      = `IBCR_LINE_IRQ_RESET;
            s_d.firmwareTimerBase      = `IBCR_TIMER_RESET;
            s_d.isaToHostDecode        = `IBCR_DECODE_RESET;
            s_d.optionRomForwardEnable = `IBCR_ROMFWD_RESET;
            s_d.readData               = 32'h0000_0000;
            s_d.nmi                    = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end

    logic readPend_q;
    always_ff @(posedge mclk) begin
        readPend_q <= !reset && hit && !cfgWrite;
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic [3:0] tom;
    logic       inHole;
    assign cfgReadData            = s_q.readData;
    assign cfgReadValid           = readPend_q;
    assign specialCycleTaken      = specialCycleSeen && s_q.commandControl[`IBCR_CMD_SPECIAL];
    assign serrDriveLow           = 1'b0;
    assign intAckResponseEn       = s_q.bridgeBusControl[`IBCR_CTRL_INTACK];
    assign earlySubtractiveDecode = s_q.bridgeBusControl[`IBCR_CTRL_EARLY];
    assign writePostingEn         = s_q.bridgeBusControl[`IBCR_CTRL_POST];
    assign delayedRetryEn         = s_q.bridgeBusControl[`IBCR_CTRL_RETRY];
    assign nmiRequest             = s_q.nmi;
    assign sgIoBase               = s_q.sgIoRelocationBase;
    assign dmaBufferConfig        = s_q.lineBufferConfig[3:0];
    assign primaryDiskIrqSelect   = s_q.diskIrqRouting[7:4];
    assign secondaryDiskIrqSelect = s_q.diskIrqRouting[3:0];
    assign lineChannels           = s_q.busIrqLineRouting;
    assign lineRouteValid = {routeOk(s_q.busIrqLineRouting[15:12]),
                             routeOk(s_q.busIrqLineRouting[11:8]),
                             routeOk(s_q.busIrqLineRouting[7:4]),
                             routeOk(s_q.busIrqLineRouting[3:0])};
    assign fwTimerHit = s_q.firmwareTimerBase[0]
                        && hostIoAddr[15:2] == s_q.firmwareTimerBase[15:2];
    assign tom    = s_q.isaToHostDecode[7:4];
    assign inHole = 1'b0;  // Hole registers live outside this bank
    // Top of memory is (tom+1) MByte; 1M..top goes to host
    always_comb begin
        isaForwardToHost = 1'b0;
        if (isaMemAddr[23:20] != 4'h0) begin
            isaForwardToHost = (isaMemAddr[23:20] <= tom) && !inHole;
        end else if (isaMemAddr[19:16] == 4'he) begin
            isaForwardToHost = s_q.isaToHostDecode[3] && !firmwareSelectReg[6];
        end else if (isaMemAddr[19:17] == 3'b101) begin
            isaForwardToHost = s_q.isaToHostDecode[2];
        end else if (isaMemAddr[19:17] == 3'b100) begin
            isaForwardToHost = s_q.isaToHostDecode[1];
        end else if (!isaMemAddr[19]) begin
            isaForwardToHost = s_q.isaToHostDecode[0];
        end
    end
    assign optionRomForward = s_q.optionRomForwardEnable;

    // ****************************************
    // Checks
    // ****************************************
    AST_CMD_FIXED: assert property (@(posedge mclk) disable iff (reset)
        s_q.commandControl[2:0] == 3'b111) else $error("command low bits not one");
    AST_CMD_ZERO: assert property (@(posedge mclk) disable iff (reset)
        (s_q.commandControl & 16'hfeb0) == 16'h0000) else $error("command reserved set");
    AST_STAT_TIMING: assert property (@(posedge mclk) disable iff (reset)
        s_q.busStatusFlags[10:9] == 2'b01 && s_q.busStatusFlags[7:0] == 8'h00)
        else $error("status fixed bits wrong");
    AST_FLAG_SET: assert property (@(posedge mclk) disable iff (reset)
        parityErrorSeen |=> s_q.busStatusFlags[15]) else $error("parity flag not set");
    AST_NMI: assert property (@(posedge mclk) disable iff (reset)
        (s_q.bridgeBusControl[0] && s_q.busStatusFlags[13]) |=> nmiRequest)
        else $error("nmi missing");
    AST_NMI_SSE: assert property (@(posedge mclk) disable iff (reset)
        ((s_q.busStatusFlags & 16'hb900) == 16'h0000) |=> !nmiRequest)
        else $error("nmi without error flag");
    AST_SPECIAL: assert property (@(posedge mclk) disable iff (reset)
        !s_q.commandControl[3] |-> !specialCycleTaken) else $error("special cycle taken");
    AST_READ_LAT: assert property (@(posedge mclk) disable iff (reset)
        (hit && !cfgWrite && idx == 6'h02) |=> cfgReadValid && cfgReadData[31:8] == 24'h060100)
        else $error("class read wrong");
    AST_ROUTE: assert property (@(posedge mclk) disable iff (reset)
        (s_q.busIrqLineRouting[3:0] == 4'hd) |-> !lineRouteValid[0])
        else $error("reserved channel routed");

    // ****************************************
    // Fixed fields and access checks
    // ****************************************
    // AST_CTRL_ZERO, AST_LINEBUF_ZERO and AST_TIMER_BIT1 watch the register image directly, so a bad mask in the
    // next-state logic shows up even when no read reaches the field.

    AST_SERR_LOW: assert property (@(posedge mclk) disable iff (reset)
        serrDriveLow == 1'b0)
        else $error("system error pin driven");

    AST_CTRL_ZERO: assert property (@(posedge mclk) disable iff (reset)
        s_q.bridgeBusControl[7] == 1'b0 && s_q.bridgeBusControl[4] == 1'b0)
        else $error("control reserved bit set");

    AST_LINEBUF_ZERO: assert property (@(posedge mclk) disable iff (reset)
        s_q.lineBufferConfig[7:4] == 4'h0)
        else $error("line buffer upper bits set");

    AST_TIMER_BIT1: assert property (@(posedge mclk) disable iff (reset)
        s_q.firmwareTimerBase[1] == 1'b0)
        else $error("timer reserved bit set");

    AST_TIMER_OFF: assert property (@(posedge mclk) disable iff (reset)
        !s_q.firmwareTimerBase[0] |-> !fwTimerHit)
        else $error("timer decoded while disabled");

    AST_SPECIAL_ON: assert property (@(posedge mclk) disable iff (reset)
        (s_q.commandControl[3] && specialCycleSeen) |-> specialCycleTaken)
        else $error("special cycle dropped");

    AST_NMI_OFF: assert property (@(posedge mclk) disable iff (reset)
        !s_q.bridgeBusControl[0] |=> !nmiRequest)
        else $error("nmi while disabled");

    // A misaligned strobe must leave no trace on the read path
    AST_MISALIGNED: assert property (@(posedge mclk) disable iff (reset)
        (cfgSelect && cfgAddr[1:0] != 2'b00) |=> !cfgReadValid)
        else $error("misaligned access answered");

    AST_WRITE_QUIET: assert property (@(posedge mclk) disable iff (reset)
        (hit && cfgWrite) |=> !cfgReadValid)
        else $error("write produced read valid");

    AST_HEADER_READ: assert property (@(posedge mclk) disable iff (reset)
        (hit && !cfgWrite && idx == 6'h03) |=> cfgReadData == 32'h0080_0000)
        else $error("header read wrong");

    AST_UNMAPPED_READ: assert property (@(posedge mclk) disable iff (reset)
        (hit && !cfgWrite && idx == 6'h12) |=> cfgReadData == 32'h0000_0000)
        else $error("unmapped read not zero");

    // Clear with no new event in the same cycle must drop the flag
    AST_FLAG_CLEAR: assert property (@(posedge mclk) disable iff (reset)
        (hit && cfgWrite && idx == 6'h01 && cfgByteEn[3] && cfgWriteData[31]
         && !parityErrorSeen) |=> !s_q.busStatusFlags[15])
        else $error("parity flag not cleared");

endmodule : ibcr_config_regs

// ==== shared/ibcr_params.svh ====
// Constants of the bridge configuration register bank: indices, reset values, fields.
// Assumes inclusion by the package and the design; definitions only.
`ifndef IBCR_PARAMS_SVH
`define IBCR_PARAMS_SVH

// Register word indices (AD[7:2])
`define IBCR_IDX_IDENT      6'h00
`define IBCR_IDX_CMDSTAT    6'h01
`define IBCR_IDX_CLASSREV   6'h02
`define IBCR_IDX_HEADER     6'h03
`define IBCR_IDX_CTRL       6'h10
`define IBCR_IDX_IRQROUTE   6'h11
`define IBCR_IDX_TIMER      6'h12
`define IBCR_IDX_DECODE     6'h13

// Reset values, masks and fixed values
`define IBCR_CMD_RESET      16'h0007
`define IBCR_CMD_FIXED_ONES 16'h0007
`define IBCR_CMD_RW_MASK    16'h0148
`define IBCR_STAT_RESET     16'h0200
`define IBCR_STAT_W1C_MASK  16'hb900
`define IBCR_STAT_ERR_MASK  16'hb900
`define IBCR_CLASS_CODE     24'h060100
`define IBCR_HEADER_TYPE    8'h80
`define IBCR_CTRL_RESET     8'h20
`define IBCR_CTRL_RW_MASK   8'h6f
`define IBCR_SG_RESET       8'h04
`define IBCR_LINEBUF_RESET  8'h00
`define IBCR_LINEBUF_MASK   8'h0f
`define IBCR_DISK_IRQ_RESET 8'hef
`define IBCR_LINE_IRQ_RESET 16'h0000
`define IBCR_TIMER_RESET    16'h0078
`define IBCR_TIMER_MASK     16'hfffd
`define IBCR_DECODE_RESET   8'h01
`define IBCR_ROMFWD_RESET   8'h00

// Field positions
`define IBCR_CMD_SPECIAL    3
`define IBCR_CMD_SERR_EN    8
`define IBCR_STAT_SSE       14
`define IBCR_CTRL_NMI_EN    0
`define IBCR_CTRL_RETRY     1
`define IBCR_CTRL_POST      2
`define IBCR_CTRL_EARLY     3
`define IBCR_CTRL_INTACK    5

`endif

// ==== shared/ibcr_pkg.sv ====
// Types of the bridge configuration register bank.
// Assumes ibcr_params.svh is on the include path.
`include "ibcr_params.svh"
package ibcr_pkg;
    typedef struct packed {
        logic [15:0] commandControl;
        logic [15:0] busStatusFlags;
        logic [7:0]  bridgeBusControl;
        logic [7:0]  sgIoRelocationBase;
        logic [7:0]  lineBufferConfig;
        logic [7:0]  diskIrqRouting;
        logic [15:0] busIrqLineRouting;
        logic [15:0] firmwareTimerBase;
        logic [7:0]  isaToHostDecode;
        logic [7:0]  optionRomForwardEnable;
        logic [31:0] readData;
        logic        nmi;
    } ibcr_state_type;
endpackage : ibcr_pkg

// ==== bench/ibcr_host_model.sv ====
// Host bridge model that issues configuration cycles to the register bank.
// Assumes mclk and reset come from the bench; one access per call, then idle.
`timescale 1ns/1ps
module ibcr_host_model (
    input  wire logic        mclk,
    input  wire logic        reset,
    output logic             cfgSelect,
    output logic             cfgWrite,
    output logic [7:0]       cfgAddr,
    output logic [3:0]       cfgByteEn,
    output logic [31:0]      cfgWriteData,
    input  wire logic [31:0] cfgReadData,
    input  wire logic        cfgReadValid
);
    initial begin
        cfgSelect = 1'b0;
        cfgWrite = 1'b0;
        cfgAddr = 8'h00;
        cfgByteEn = 4'h0;
        cfgWriteData = 32'h0;
    end
    // ****************************************
    // Access task
    // ****************************************
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic [31:0] q, output logic v);
        @(posedge mclk);
        while (reset === 1'b1) @(posedge mclk);
        #1;
        cfgSelect = 1'b1;
        cfgWrite = wr;
        cfgAddr = a;
        cfgByteEn = be;
        cfgWriteData = d;
        @(posedge mclk);
        #1;
        q = cfgReadData;
        v = cfgReadValid;
        // Released lines are inverted so a stale value never passes as a live one
        cfgSelect = 1'b0;
        cfgWrite = ~wr;
        cfgAddr = ~a;
        cfgByteEn = ~be;
        cfgWriteData = ~d;
    endtask : access
endmodule : ibcr_host_model

// ==== bench/ibcr_config_regs_test.sv ====
// Self-checking bench of the bridge configuration register bank.
// Assumes ibcr_host_model drives the config strobe; bench drives side inputs.
`timescale 1ns/1ps
module ibcr_config_regs_test;
    logic mclk, reset, specialCycleSeen;
    logic [5:0] errPulse;
    logic [23:0] isaMemAddr;
    logic [7:0] firmwareSelectReg;
    logic [15:0] hostIoAddr;
    logic cfgSelect, cfgWrite, cfgReadValid, specialCycleTaken, serrDriveLow, fwTimerHit;
    logic intAckResponseEn, earlySubtractiveDecode, writePostingEn, delayedRetryEn;
    logic nmiRequest, isaForwardToHost;
    logic [7:0] cfgAddr, sgIoBase, optionRomForward;
    logic [3:0] cfgByteEn, dmaBufferConfig, primaryDiskIrqSelect, secondaryDiskIrqSelect;
    logic [3:0] lineRouteValid;
    logic [31:0] cfgWriteData, cfgReadData;
    logic [15:0] lineChannels;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    wire [31:0] ctrlOuts = {26'h0, intAckResponseEn, earlySubtractiveDecode,
                            writePostingEn, delayedRetryEn, nmiRequest, serrDriveLow};
    // Revision value is arbitrary
    ibcr_config_regs #(.REVISION(8'h5a)) dut (.mclk(mclk), .reset(reset),
        .cfgSelect(cfgSelect), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
        .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
        .cfgReadValid(cfgReadValid), .parityErrorSeen(errPulse[0]),
        .masterAbortReceived(errPulse[1]), .targetAbortReceived(errPulse[2]),
        .targetAbortSignaled(errPulse[3]), .masterParityError(errPulse[4]),
        .systemErrorSignaled(errPulse[5]), .specialCycleSeen(specialCycleSeen),
        .isaMemAddr(isaMemAddr), .firmwareSelectReg(firmwareSelectReg),
        .hostIoAddr(hostIoAddr), .specialCycleTaken(specialCycleTaken),
        .serrDriveLow(serrDriveLow), .intAckResponseEn(intAckResponseEn),
        .earlySubtractiveDecode(earlySubtractiveDecode), .writePostingEn(writePostingEn),
        .delayedRetryEn(delayedRetryEn), .nmiRequest(nmiRequest), .sgIoBase(sgIoBase),
        .dmaBufferConfig(dmaBufferConfig), .primaryDiskIrqSelect(primaryDiskIrqSelect),
        .secondaryDiskIrqSelect(secondaryDiskIrqSelect), .lineChannels(lineChannels),
        .lineRouteValid(lineRouteValid), .fwTimerHit(fwTimerHit),
        .isaForwardToHost(isaForwardToHost), .optionRomForward(optionRomForward));
    ibcr_host_model host (.mclk(mclk), .reset(reset), .cfgSelect(cfgSelect),
        .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Hang guard: a full run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        logic v;
        host.access(1'b1, a, be, d, q, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic v;
        host.access(1'b0, a, 4'hf, 32'h0, q, v);
        check("read valid", {31'h0, v}, 32'h1);
        check("read data", q, exp);
    endtask : rd
    task automatic pulse(input int i);
        @(posedge mclk);
        #1 errPulse[i] = 1'b1;
        @(posedge mclk);
        #1 errPulse = 6'h0;
    endtask : pulse
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0] rstAddr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40, 8'h44, 8'h48, 8'h4c};
        logic [31:0] rstVal [8] = '{32'h0, 32'h02000007, 32'h0601005a, 32'h00800000,
                                    32'hef000420, 32'h00780000, 32'h0, 32'h00000001};
        logic [39:0] tab [12] = '{40'h3f00050000, 40'h3f00090000, 40'h3f000b0000,
            40'h3f000e8000, 40'h3f400e8000, 40'h3f000f0000, 40'h3f003fffff,
            40'h3f00400000, 40'h3000050000, 40'h3000100000, 40'h0000100000, 40'hf000ffffff};
        logic [11:0] fwdExp = 12'ha4f;
        logic [31:0] q;
        logic v;
        reset = 1'b1;
        errPulse = 6'h0;
        specialCycleSeen = 1'b0;
        isaMemAddr = 24'h0;
        firmwareSelectReg = 8'h00;
        hostIoAddr = 16'h0;
        repeat (5) @(posedge mclk);
        #1 reset = 1'b0;
        for (int i = 0; i < 8; i++) rd(rstAddr[i], rstVal[i]);
        check("ctrl outs", ctrlOuts, 32'h20);
        wr(8'h04, 4'h3, 32'h0000ffff);
        rd(8'h04, 32'h0200014f);
        specialCycleSeen = 1'b1;
        #1 check("special", {31'h0, specialCycleTaken}, 32'h1);
        check("serr", {31'h0, serrDriveLow}, 32'h0);
        wr(8'h04, 4'h1, 32'h0);
        check("special", {31'h0, specialCycleTaken}, 32'h0);
        specialCycleSeen = 1'b0;
        wr(8'h40, 4'h1, 32'h21);
        pulse(5);
        repeat (2) @(posedge mclk);
        #1 check("nmi", {31'h0, nmiRequest}, 32'h0);
        rd(8'h04, 32'h42000107);
        pulse(0);
        repeat (2) @(posedge mclk);
        #1 check("nmi", {31'h0, nmiRequest}, 32'h1);
        for (int i = 1; i < 5; i++) pulse(i);
        rd(8'h04, 32'hfb000107);
        wr(8'h04, 4'hc, 32'h7fff0000);
        rd(8'h04, 32'h82000107);
        wr(8'h04, 4'h8, 32'h80000000);
        repeat (2) @(posedge mclk);
        #1 check("nmi", {31'h0, nmiRequest}, 32'h0);
        wr(8'h40, 4'hf, 32'h5aff12ff);
        rd(8'h40, 32'h5a0f126f);
        check("ctrl outs", ctrlOuts, 32'h3c);
        check("route outs", {12'h0, sgIoBase, dmaBufferConfig, primaryDiskIrqSelect,
              secondaryDiskIrqSelect}, 32'h00012f5a);
        wr(8'h40, 4'h1, 32'h0);
        check("ctrl outs", ctrlOuts, 32'h0);
        for (int k = 0; k < 16; k++) begin
            wr(8'h44, 4'h3, {16'h0, {4{k[3:0]}}});
            check("line chan", {16'h0, lineChannels}, {16'h0, {4{k[3:0]}}});
            check("line valid", {28'h0, lineRouteValid},
                  (k inside {0, 1, 2, 8, 13}) ? 32'h0 : 32'hf);
        end
        wr(8'h44, 4'hc, 32'hffff0000);
        rd(8'h44, 32'hfffdffff);
        wr(8'h44, 4'hc, 32'h03010000);
        hostIoAddr = 16'h0302;
        #1 check("timer hit", {31'h0, fwTimerHit}, 32'h1);
        hostIoAddr = 16'h0304;
        #1 check("timer hit", {31'h0, fwTimerHit}, 32'h0);
        hostIoAddr = 16'h0300;
        wr(8'h44, 4'hc, 32'h03000000);
        check("timer hit", {31'h0, fwTimerHit}, 32'h0);
        for (int i = 0; i < 12; i++) begin
            wr(8'h4c, 4'h1, {24'h0, tab[i][39:32]});
            firmwareSelectReg = tab[i][31:24];
            isaMemAddr = tab[i][23:0];
            #1 check("isa fwd", {31'h0, isaForwardToHost}, {31'h0, fwdExp[i]});
        end
        wr(8'h4c, 4'h2, 32'h0000a500);
        check("rom fwd", {24'h0, optionRomForward}, 32'ha5);
        rd(8'h4c, 32'h0000a5f0);
        wr(8'h48, 4'hf, 32'hffffffff);
        rd(8'h48, 32'h0);
        wr(8'h08, 4'hf, 32'hffffffff);
        wr(8'h0c, 4'hf, 32'hffffffff);
        rd(8'h08, 32'h0601005a);
        rd(8'h0c, 32'h00800000);
        host.access(1'b0, 8'h41, 4'hf, 32'h0, q, v);
        check("misaligned valid", {31'h0, v}, 32'h0);
        end_of_test();
    end
endmodule : ibcr_config_regs_test
